// [rtl/wbt_top.sv]
// watchdog fast-test block top: apb registers, write-once config, reset cause
// assumes rst_n is power-on reset; the watchdog hold state drives the internal
// non-power-on reset, extPinRst is the external pin reset
`timescale 1ns/1ps
module wbt_top import wbt_pkg::*; #(
  parameter int REF_DIV = WBT_REF_DIV
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // other reset causes
  input wire logic extPinRst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // outputs
  output logic sysRstReq,
  output logic irq
);
  wbt_cfg_s cfg;
  wbt_state_e state;
  logic [1:0] testSelect; // survives all but power-on reset
  logic [1:0] pendTst;
  logic pendEn;
  logic [15:0] pendTo;
  logic [1:0] wrDone; // bit0 control, bit1 timeout
  logic ctrlLocked, toHLocked, toLLocked;
  logic porFlag, wdgFlag;
  logic [1:0] evStat;
  logic [1:0] evMask;
  logic [31:0] holdCnt;
  logic [15:0] count;
  logic hit, tick;

  // internal reset: power-on or any non-power-on source
  wire softRst = (state == WBT_HOLD) || extPinRst;
  wire anyRst_n = rst_n && !softRst;

  // apb decode
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire selCtrl = (paddr == WBT_OFF_CTRL);
  wire selToH = (paddr == WBT_OFF_TOH);
  wire selToL = (paddr == WBT_OFF_TOL);
  wire selCntH = (paddr == WBT_OFF_CNTH);
  wire selCntL = (paddr == WBT_OFF_CNTL);
  wire selRstat = (paddr == WBT_OFF_RSTAT);
  wire selIrq = (paddr == WBT_OFF_IRQ);
  wire selMask = (paddr == WBT_OFF_MASK);
  wire mapped = selCtrl | selToH | selToL | selCntH | selCntL | selRstat | selIrq | selMask;
  wire [1:0] wrTst = pwdata[WBT_CTRL_TST_LSB +: 2];
  wire fireNow = (state == WBT_RUN) && hit && tick && cfg.en;
  wire [1:0] evSet = {fireNow && (cfg.tst == WBT_TST_LOW || cfg.tst == WBT_TST_HIGH), fireNow};
  // test select reads back from its power-on-only register, so a test reset keeps it
  wire [31:0] rdMux = selCtrl ? 32'({testSelect, 3'h0, cfg.en}) :
    selToH ? 32'(cfg.timeout[15:8]) :
    selToL ? 32'(cfg.timeout[7:0]) :
    selCntH ? 32'(count[15:8]) :
    selCntL ? 32'(count[7:0]) :
    selRstat ? 32'({wdgFlag, porFlag}) :
    selIrq ? 32'(evStat) :
    selMask ? 32'(evMask) : 32'h0;

  wbt_tick #(.DIV(REF_DIV)) uTick (
    .clk(clk),
    .rst_n(anyRst_n),
    .tick(tick)
  );

  wbt_counter uCnt (
    .clk(clk),
    .rst_n(anyRst_n),
    .tick(tick),
    .clr(1'b0),
    .cfg(cfg),
    .count(count),
    .hit(hit)
  );

  // test select is only cleared by power-on reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      testSelect <= WBT_TST_NONE;
    end else if (wrEn && selCtrl && !ctrlLocked) begin
      testSelect <= wrTst;
    end
  end

  // write-once staging; cleared by every reset
  always_ff @(posedge clk) begin
    if (!anyRst_n) begin
      ctrlLocked <= 1'b0;
      toHLocked <= 1'b0;
      toLLocked <= 1'b0;
      pendEn <= 1'b0;
      pendTst <= WBT_TST_NONE;
      pendTo <= WBT_TO_RESET;
      wrDone <= 2'h0;
    end else if (wrEn) begin
      if (selCtrl && !ctrlLocked) begin
        ctrlLocked <= 1'b1;
        pendEn <= pwdata[WBT_CTRL_EN_BIT];
        pendTst <= wrTst;
        wrDone[0] <= 1'b1;
      end
      if (selToH && !toHLocked) begin
        toHLocked <= 1'b1;
        pendTo[15:8] <= pwdata[7:0];
      end
      if (selToL && !toLLocked) begin
        toLLocked <= 1'b1;
        pendTo[7:0] <= pwdata[7:0];
      end
      wrDone[1] <= (toHLocked || selToH) && (toLLocked || selToL);
    end
  end

  // live config: reset defaults until every register written once
  always_ff @(posedge clk) begin
    if (!anyRst_n) begin
      cfg <= '{tst: WBT_TST_NONE, en: 1'b1, timeout: WBT_TO_RESET};
    end else if (wrDone == WBT_CFG_ALL) begin
      cfg <= '{tst: pendTst, en: pendEn, timeout: pendTo};
    end
  end

  // timeout sequencer: fire then hold the internal reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= WBT_RUN;
      holdCnt <= 32'h0;
    end else begin
      case (state)
        WBT_RUN: begin
          if (fireNow) begin
            state <= WBT_FIRE;
          end
        end
        WBT_FIRE: begin
          state <= WBT_HOLD;
          holdCnt <= 32'(WBT_RST_HOLD - 1);
        end
        WBT_HOLD: begin
          if (holdCnt == 32'h0) begin
            state <= WBT_RUN;
          end else begin
            holdCnt <= holdCnt - 32'h1;
          end
        end
        default: begin
          state <= WBT_RUN;
        end
      endcase
    end
  end

  // reset cause flags; reading status leaves them, watchdog fire wins over pin reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      porFlag <= 1'b1;
      wdgFlag <= 1'b0;
    end else if (state == WBT_FIRE) begin
      wdgFlag <= 1'b1;
      porFlag <= 1'b0;
    end else if (extPinRst) begin
      wdgFlag <= 1'b0;
      porFlag <= 1'b0;
    end
  end

  // sticky events: bit0 timeout, bit1 test timeout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evStat <= 2'h0;
      evMask <= 2'h0;
    end else begin
      evStat <= (rdEn && selIrq ? 2'h0 : evStat) | evSet;
      if (wrEn && selMask) begin
        evMask <= pwdata[1:0];
      end
    end
  end

  // apb response, no wait states; unmapped gives slverr
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sysRstReq <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
      sysRstReq <= (state == WBT_FIRE) || (state == WBT_HOLD);
      irq <= |(evStat & evMask);
    end
  end
endmodule

// [rtl/wbt_pkg.sv]
// constants, register map and carrier types for the watchdog byte fast test
// assumes a 200 MHz system clock and an apb master of 32-bit data
// What this block does
// - test select 10b low byte, 11b high
// - tested byte reaching timeout byte forces reset
// - watchdog reset sets cause flag, not por
// - test select reads back pattern after reset
// - test select cleared by power-on reset only
// - pattern 01b marks tested, user operation
// - counter high and low readable anytime
// - byte stages; high byte clocked via bit 8
// - config write-once; active after all written
// - power-on reset sets por flag
package wbt_pkg;
  localparam logic [7:0] WBT_OFF_CTRL = 8'h00; // guard_control_one
  localparam logic [7:0] WBT_OFF_TOH = 8'h04; // timeout_value_high
  localparam logic [7:0] WBT_OFF_TOL = 8'h08; // timeout_value_low
  localparam logic [7:0] WBT_OFF_CNTH = 8'h0c; // counter_value_high
  localparam logic [7:0] WBT_OFF_CNTL = 8'h10; // counter_value_low
  localparam logic [7:0] WBT_OFF_RSTAT = 8'h14; // reset status
  localparam logic [7:0] WBT_OFF_IRQ = 8'h18; // sticky events, read clears
  localparam logic [7:0] WBT_OFF_MASK = 8'h1c; // interrupt mask
  localparam logic [1:0] WBT_TST_NONE = 2'h0;
  localparam logic [1:0] WBT_TST_USER = 2'h1;
  localparam logic [1:0] WBT_TST_LOW = 2'h2;
  localparam logic [1:0] WBT_TST_HIGH = 2'h3;
  localparam logic [15:0] WBT_TO_RESET = 16'h0004; // about 4 ms at 1 kHz
  localparam int WBT_CTRL_EN_BIT = 0;
  localparam int WBT_CTRL_TST_LSB = 4;
  localparam int WBT_RSTAT_POR_BIT = 0;
  localparam int WBT_RSTAT_WDG_BIT = 1;
  localparam int WBT_REF_HZ = 1000;
  localparam int WBT_CLK_HZ = 200000000;
  localparam int WBT_REF_DIV = WBT_CLK_HZ / WBT_REF_HZ;
  localparam int WBT_RST_HOLD_NS = 100;
  localparam int WBT_RST_HOLD = (WBT_RST_HOLD_NS * 200 + 999) / 1000;
  localparam logic [1:0] WBT_CFG_ALL = 2'h3;

  typedef struct packed {
    logic [1:0] tst;
    logic en;
    logic [15:0] timeout;
  } wbt_cfg_s;

  typedef enum logic [1:0] {
    WBT_RUN = 2'b00,
    WBT_FIRE = 2'b01,
    WBT_HOLD = 2'b11
  } wbt_state_e;
endpackage

// [rtl/wbt_tick.sv]
// reference tick divider: one-cycle enable at the watchdog reference rate
// assumes a single system clock and synchronous reset
`timescale 1ns/1ps
module wbt_tick import wbt_pkg::*; #(
  parameter int DIV = WBT_REF_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // tick pulse
  output logic tick
);
  logic [31:0] count;

  // count down, pulse on wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (count == 32'h0);
      count <= (count == 32'h0) ? 32'(DIV - 1) : count - 32'h1;
    end
  end
endmodule

// [rtl/wbt_counter.sv]
// watchdog counter with byte-split fast test and compare
// assumes tick is a one-cycle enable and clr clears the count
`timescale 1ns/1ps
module wbt_counter import wbt_pkg::*; (
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clr,
  input wire wbt_cfg_s cfg,
  // state
  output logic [15:0] count,
  output logic hit
);
  wire testLow = (cfg.tst == WBT_TST_LOW);
  wire testHigh = (cfg.tst == WBT_TST_HIGH);
  // low byte carry into bit 8 drives the high stage in high-byte test
  wire lowWrap = (count[7:0] == 8'hff);
  wire [7:0] next_low = count[7:0] + 8'h1;
  wire [7:0] next_high = count[15:8] + 8'h1;
  wire [15:0] next_count = testLow ? {count[15:8], next_low} :
    testHigh ? (lowWrap ? {next_high, 8'h00} : {count[15:8], next_low}) :
    count + 16'h1;

  // compare only the tested byte, else the full value
  assign hit = testLow ? (count[7:0] == cfg.timeout[7:0]) :
    testHigh ? (count[15:8] == cfg.timeout[15:8]) :
    (count == cfg.timeout);

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      count <= 16'h0;
    end else if (tick && cfg.en) begin
      count <= next_count;
    end
  end
endmodule

// [testbench/wbt_asserts.sv]
// port-level checks for the watchdog fast-test top
// assumes one clock domain and the top's ports only
`timescale 1ns/1ps
module wbt_asserts import wbt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic sysRstReq,
  input wire logic irq
);
  // one domain, so clock and disable are declared once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_in_access: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error outside answer or with data");
  a_unmapped_err: assert property (psel && !penable && paddr > WBT_OFF_MASK |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (psel && !penable && paddr <= WBT_OFF_MASK
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  // 21 cycles of reset request: fire plus hold
  a_reset_hold: assert property ($rose(sysRstReq) |-> sysRstReq[*8] ##13 sysRstReq
    ##1 !sysRstReq)
    else $error("reset request length wrong");
  a_release_quiet: assert property ($rose(rst_n) |-> !sysRstReq && !irq && !pready)
    else $error("outputs not clear after reset");
endmodule

bind wbt_top wbt_asserts u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sysRstReq(sysRstReq), .irq(irq));

// [testbench/wbt_top_test.sv]
// self-checking bench for the watchdog fast-test top over apb
// assumes a short reference divider so byte tests finish quickly
`timescale 1ns/1ps
module wbt_top_test import wbt_pkg::*;;
  localparam int DIV = 8;
  logic clk = 0, rst_n = 0, extPinRst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, tol, cnt;
  logic pready, pslverr, sysRstReq, irq;
  logic [1:0] pat;
  int bad_count = 0, tests_run = 0, cyc = 0, seed = 83, t0, lv;
  always #2.5 clk = ~clk;
  wbt_top #(.REF_DIV(DIV)) DUT (.clk(clk), .rst_n(rst_n), .extPinRst(extPinRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysRstReq(sysRstReq), .irq(irq));
  task end_sim;
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // time from t0 to the reset request, then wait out the hold
  task fire(input int lo, input int hi);
    while (sysRstReq !== 1'b1 && cyc - t0 < 5000) @(posedge clk);
    chk(32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
    while (sysRstReq === 1'b1) @(posedge clk);
  endtask
  // cycle ceiling: the longest path is one high-byte test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(WBT_OFF_RSTAT, 32'h3, 32'h1);
    rdc(WBT_OFF_CTRL, 32'h30, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, WBT_OFF_MASK, 32'h3);
    // low byte then high byte; the other timeout byte is chosen so a
    // full compare would fire far outside the window
    for (int i = 0; i < 2; i++) begin
      pat = i ? WBT_TST_HIGH : WBT_TST_LOW;
      lv = 4 + $unsigned($random(seed)) % 5;
      tol = i ? 32'h80 | ($random(seed) & 32'h7f) : 32'(lv);
      apb(1'b1, WBT_OFF_TOH, i ? 32'h1 : 32'h10 | ($random(seed) & 32'hf0));
      apb(1'b1, WBT_OFF_TOL, tol);
      apb(1'b1, WBT_OFF_CTRL, {26'h0, pat, 4'h1});
      t0 = cyc;
      apb(1'b1, WBT_OFF_TOL, 32'h0);
      rdc(WBT_OFF_TOL, 32'hff, tol);
      fire(i ? 253 * DIV : (lv - 3) * DIV, i ? 258 * DIV : (lv + 2) * DIV);
      chk(irq, 1'b1);
      rdc(WBT_OFF_RSTAT, 32'h3, 32'h2);
      rdc(WBT_OFF_CTRL, 32'h30, {26'h0, pat, 4'h0});
      rdc(WBT_OFF_IRQ, 32'h2, 32'h2);
      rdc(WBT_OFF_IRQ, 32'h3, 32'h0);
      chk(irq, 1'b0);
    end
    // user mode: full 16-bit compare, counter visible while it runs
    lv = 6 + $unsigned($random(seed)) % 5;
    apb(1'b1, WBT_OFF_TOH, 32'h0);
    apb(1'b1, WBT_OFF_TOL, 32'(lv));
    apb(1'b1, WBT_OFF_CTRL, {26'h0, WBT_TST_USER, 4'h1});
    t0 = cyc;
    apb(1'b0, WBT_OFF_CNTL, 32'h0);
    cnt = rd;
    repeat (2 * DIV) @(posedge clk);
    apb(1'b0, WBT_OFF_CNTL, 32'h0);
    chk(32'(rd > cnt), 32'h1);
    fire((lv - 3) * DIV, (lv + 2) * DIV);
    rdc(WBT_OFF_RSTAT, 32'h3, 32'h2);
    rdc(WBT_OFF_CTRL, 32'h30, 32'h10);
    rdc(WBT_OFF_IRQ, 32'h3, 32'h1);
    // pin reset keeps the test pattern, power-on reset clears it
    extPinRst <= 1'b1;
    repeat (3) @(posedge clk);
    extPinRst <= 1'b0;
    rdc(WBT_OFF_CTRL, 32'h30, 32'h10);
    rdc(WBT_OFF_RSTAT, 32'h3, 32'h0);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(WBT_OFF_CTRL, 32'h30, 32'h0);
    rdc(WBT_OFF_RSTAT, 32'h3, 32'h1);
    end_sim;
  end
endmodule
